// File: accumulator_xor_compare_unit.sv
// Accumulator exclusive-or and compare unit with accumulator stack and status flags.
//
// Operation
// - Word xor: low accumulator half xored with memory word, written back.
// - Every xor form sets zero flag when result is zero, else clears.
// - Every xor form sets negative flag exactly when result bit 31 is one.
// - Double xor: full 32-bit accumulator xored with immediate constant.
// - Bit-range xor: accumulator xored with a run of 1 to 32 bits.
// - Stack xor: accumulator xored with stack level one, then stack pops.
// - Word compare: low accumulator half against memory word sets compare flags.
// - Any compare asserts exactly one of less, equal, greater.
// - Double compare: full accumulator against two words or a constant.
// - Bit-range compare: accumulator against a run of 1 to 32 bits.
// - Each flag holds until the next instruction that updates that flag.
// - Compares leave the accumulator unchanged.
`timescale 1ns/10ps

module accumulator_xor_compare_unit #(
  parameter int STACK_DEPTH = acc_xor_cmp_pkg::STACK_DEPTH
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Instruction from the sequencer.
  input wire logic i_valid,
  input wire acc_xor_cmp_pkg::instr_t i_instr,
  // Accumulator load and stack push from other instructions.
  input wire logic i_load,
  input wire logic [31:0] i_load_value,
  input wire logic i_push,
  // Results.
  output logic [31:0] o_acc,
  output logic [31:0] o_stack_top,
  output acc_xor_cmp_pkg::flags_t o_flags,
  output logic o_done
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic [31:0] stack_q [STACK_DEPTH];
  logic [31:0] stack_d [STACK_DEPTH];
  acc_xor_cmp_pkg::flags_t flags_q;
  acc_xor_cmp_pkg::flags_t flags_d;
  logic done_q;
  logic done_d;

  // ****************************************************************
  // Operand shaping
  // ****************************************************************
  logic [31:0] range_mask;
  logic [31:0] range_val;
  logic [31:0] xor_res;
  logic [31:0] cmp_a;
  logic [31:0] cmp_b;
  logic is_xor;
  logic is_cmp;
  logic do_pop;

  // A count outside 1..32 is clamped so the run never reaches past 32 bits.
  always_comb begin
    range_mask = 32'h0000_0000;
    for (int i = 0; i < acc_xor_cmp_pkg::MAX_BITS; i++) begin
      if (i < int'(i_instr.bit_count) || i_instr.bit_count > 6'h20) begin
        range_mask[i] = 1'b1;
      end
    end
    if (i_instr.bit_count == 6'h00) begin
      range_mask = 32'h0000_0001;
    end
    range_val = i_instr.operand & range_mask;
  end

  always_comb begin
    is_xor = i_valid && (i_instr.op inside {acc_xor_cmp_pkg::OP_XOR_WORD, acc_xor_cmp_pkg::OP_XOR_DOUBLE,
                                            acc_xor_cmp_pkg::OP_XOR_BIT_RANGE,
                                            acc_xor_cmp_pkg::OP_XOR_WITH_STACK});
    is_cmp = i_valid && (i_instr.op inside {acc_xor_cmp_pkg::OP_COMPARE_WORD, acc_xor_cmp_pkg::OP_COMPARE_DOUBLE,
                                            acc_xor_cmp_pkg::OP_COMPARE_BIT_RANGE});
    do_pop = i_valid && i_instr.op == acc_xor_cmp_pkg::OP_XOR_WITH_STACK;
    xor_res = acc_q;
    cmp_a = acc_q;
    cmp_b = i_instr.operand;
    unique case (i_instr.op)
      acc_xor_cmp_pkg::OP_XOR_WORD: begin
        xor_res = {acc_q[31:16], acc_q[15:0] ^ i_instr.operand[15:0]};
      end
      acc_xor_cmp_pkg::OP_XOR_DOUBLE: begin
        xor_res = acc_q ^ i_instr.operand;
      end
      acc_xor_cmp_pkg::OP_XOR_BIT_RANGE: begin
        xor_res = acc_q ^ range_val;
      end
      acc_xor_cmp_pkg::OP_XOR_WITH_STACK: begin
        xor_res = acc_q ^ stack_q[0];
      end
      acc_xor_cmp_pkg::OP_COMPARE_WORD: begin
        cmp_a = {16'h0000, acc_q[15:0]};
        cmp_b = {16'h0000, i_instr.operand[15:0]};
      end
      acc_xor_cmp_pkg::OP_COMPARE_DOUBLE: begin
        cmp_b = i_instr.operand;
      end
      acc_xor_cmp_pkg::OP_COMPARE_BIT_RANGE: begin
        cmp_b = range_val;
      end
      acc_xor_cmp_pkg::OP_NONE: begin
        cmp_b = i_instr.operand;
      end
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    acc_d = acc_q;
    flags_d = flags_q;
    done_d = i_valid;
    for (int i = 0; i < STACK_DEPTH; i++) begin
      stack_d[i] = stack_q[i];
    end
    if (is_xor) begin
      acc_d = xor_res;
      flags_d.zero_result_flag = (xor_res == 32'h0000_0000);
      flags_d.negative_result_flag = xor_res[31];
    end else if (is_cmp) begin
      // Accumulator keeps its value on compares.
      flags_d.less_than_flag = cmp_a < cmp_b;
      flags_d.equal_flag = cmp_a == cmp_b;
      flags_d.greater_than_flag = cmp_a > cmp_b;
    end else if (i_load) begin
      acc_d = i_load_value;
      if (i_push) begin
        stack_d[0] = acc_q;
        for (int i = 1; i < STACK_DEPTH; i++) begin
          stack_d[i] = stack_q[i - 1];
        end
      end
    end
    if (do_pop) begin
      // Deepest level refills with zero as every level moves up.
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        stack_d[i] = stack_q[i + 1];
      end
      stack_d[STACK_DEPTH - 1] = 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      acc_q <= acc_xor_cmp_pkg::ACC_RESET;
      flags_q <= acc_xor_cmp_pkg::FLAGS_RESET;
      done_q <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_q[i] <= 32'h0000_0000;
      end
    end else begin
      acc_q <= acc_d;
      flags_q <= flags_d;
      done_q <= done_d;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_q[i] <= stack_d[i];
      end
    end
  end

  assign o_acc = acc_q;
  assign o_flags = flags_q;
  assign o_done = done_q;
  assign o_stack_top = stack_q[0];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  sequence xor_word_s;
    i_valid && i_instr.op == acc_xor_cmp_pkg::OP_XOR_WORD;
  endsequence

  xor_word_result_a: assert property (xor_word_s |=> o_acc == {$past(acc_q[31:16]),
      $past(acc_q[15:0]) ^ $past(i_instr.operand[15:0])}) else $error("word xor result wrong");
  zero_flag_a: assert property (is_xor |=> o_flags.zero_result_flag == (o_acc == 32'h0))
    else $error("zero flag wrong");
  negative_flag_a: assert property (is_xor |=> o_flags.negative_result_flag == o_acc[31])
    else $error("negative flag wrong");
  xor_double_a: assert property (i_valid && i_instr.op == acc_xor_cmp_pkg::OP_XOR_DOUBLE
      |=> o_acc == ($past(acc_q) ^ $past(i_instr.operand))) else $error("double xor wrong");
  stack_pop_a: assert property (do_pop |=> o_acc == ($past(acc_q) ^ $past(stack_q[0]))
      && o_stack_top == $past(stack_q[1])) else $error("stack xor pop wrong");
  one_hot_cmp_a: assert property (is_cmp |=> $onehot({o_flags.less_than_flag,
      o_flags.equal_flag, o_flags.greater_than_flag})) else $error("compare flags not one-hot");
  cmp_keeps_acc_a: assert property (is_cmp |=> $stable(o_acc)) else $error("compare changed acc");
  flags_hold_a: assert property (!is_xor && !is_cmp |=> $stable(o_flags))
    else $error("flags changed without update");
  word_cmp_equal_a: assert property (i_valid && i_instr.op == acc_xor_cmp_pkg::OP_COMPARE_WORD
      && acc_q[15:0] == i_instr.operand[15:0] |=> o_flags.equal_flag) else $error("word compare wrong");
  range_zero_a: assert property (i_valid && i_instr.op == acc_xor_cmp_pkg::OP_XOR_BIT_RANGE
      && i_instr.bit_count == 6'h04 |=> o_acc[31:4] == $past(acc_q[31:4])) else $error("range overreach");

  // ****************************************************************
  // Reference run mask
  // ****************************************************************
  // The checks build their own run mask by one shift instead of the per-bit loop,
  // so a slip in the loop cannot hide behind an identical expectation.
  logic [5:0] ref_count;
  logic [31:0] ref_mask;

  always_comb begin
    ref_count = i_instr.bit_count;
    if (i_instr.bit_count < 6'(acc_xor_cmp_pkg::MIN_BITS)) begin
      ref_count = 6'(acc_xor_cmp_pkg::MIN_BITS);
    end else if (i_instr.bit_count > 6'(acc_xor_cmp_pkg::MAX_BITS)) begin
      ref_count = 6'(acc_xor_cmp_pkg::MAX_BITS);
    end
    ref_mask = 32'((33'h1 << ref_count) - 33'h1);
  end

  // ****************************************************************
  // Checks per instruction form
  // ****************************************************************
  sequence range_xor_s;
    i_valid && i_instr.op == acc_xor_cmp_pkg::OP_XOR_BIT_RANGE;
  endsequence

  sequence range_cmp_s;
    i_valid && i_instr.op == acc_xor_cmp_pkg::OP_COMPARE_BIT_RANGE;
  endsequence

  sequence double_cmp_s;
    i_valid && i_instr.op == acc_xor_cmp_pkg::OP_COMPARE_DOUBLE;
  endsequence

  sequence word_cmp_s;
    i_valid && i_instr.op == acc_xor_cmp_pkg::OP_COMPARE_WORD;
  endsequence

  // A word xor must not disturb the upper half of the accumulator.
  word_xor_upper_a: assert property (xor_word_s
      |=> o_acc[31:16] == $past(acc_q[31:16]))
    else $error("word xor touched upper half");

  range_xor_result_a: assert property (range_xor_s
      |=> o_acc == ($past(acc_q) ^ ($past(i_instr.operand) & $past(ref_mask))))
    else $error("bit-range xor result wrong");

  range_xor_outside_a: assert property (range_xor_s
      |=> ((o_acc ^ $past(acc_q)) & ~$past(ref_mask)) == 32'h0000_0000)
    else $error("bit-range xor changed bits past the run");

  range_cmp_equal_a: assert property (range_cmp_s
      |=> o_flags.equal_flag == ($past(acc_q) == ($past(i_instr.operand) & $past(ref_mask))))
    else $error("bit-range compare equal wrong");

  range_cmp_less_a: assert property (range_cmp_s
      |=> o_flags.less_than_flag == ($past(acc_q) < ($past(i_instr.operand) & $past(ref_mask))))
    else $error("bit-range compare less wrong");

  double_cmp_less_a: assert property (double_cmp_s
      |=> o_flags.less_than_flag == ($past(acc_q) < $past(i_instr.operand)))
    else $error("double compare less wrong");

  double_cmp_greater_a: assert property (double_cmp_s
      |=> o_flags.greater_than_flag == ($past(acc_q) > $past(i_instr.operand)))
    else $error("double compare greater wrong");

  word_cmp_less_a: assert property (word_cmp_s
      |=> o_flags.less_than_flag == ($past(acc_q[15:0]) < $past(i_instr.operand[15:0])))
    else $error("word compare less wrong");

  // Only the low halves count, whatever rides in the upper halves.
  word_cmp_greater_a: assert property (word_cmp_s
      |=> o_flags.greater_than_flag == ($past(acc_q[15:0]) > $past(i_instr.operand[15:0])))
    else $error("word compare greater wrong");

  cmp_keeps_result_a: assert property (is_cmp
      |=> $stable({o_flags.zero_result_flag, o_flags.negative_result_flag}))
    else $error("compare changed zero or negative flag");

  xor_keeps_cmp_a: assert property (is_xor
      |=> $stable({o_flags.less_than_flag, o_flags.equal_flag, o_flags.greater_than_flag}))
    else $error("xor changed compare flags");

  // The deepest level refills with zero, so stale data never resurfaces.
  pop_refill_a: assert property (do_pop
      |=> stack_q[STACK_DEPTH - 1] == 32'h0000_0000)
    else $error("stack pop refill wrong");

  pop_shift_a: assert property (do_pop
      |=> stack_q[STACK_DEPTH - 2] == $past(stack_q[STACK_DEPTH - 1]))
    else $error("stack pop shift wrong");

  cmp_ignores_load_a: assert property (is_cmp && i_load
      |=> $stable(o_acc) && $stable(o_stack_top))
    else $error("compare let a load through");

endmodule : accumulator_xor_compare_unit

// File: acc_xor_cmp_pkg.sv
// Package with opcodes, widths and reset values for the accumulator xor/compare unit.
package acc_xor_cmp_pkg;

  localparam int ACC_W = 32;
  localparam int HALF_W = 16;
  localparam int CNT_W = 6;
  localparam int STACK_DEPTH = 8;
  localparam int MIN_BITS = 1;
  localparam int MAX_BITS = 32;
  localparam logic [31:0] ACC_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    OP_XOR_WORD = 3'h0,
    OP_XOR_DOUBLE = 3'h1,
    OP_XOR_BIT_RANGE = 3'h2,
    OP_XOR_WITH_STACK = 3'h3,
    OP_COMPARE_WORD = 3'h4,
    OP_COMPARE_DOUBLE = 3'h5,
    OP_COMPARE_BIT_RANGE = 3'h6,
    OP_NONE = 3'h7
  } opcode_t;

  // One instruction as the sequencer hands it over.
  typedef struct packed {
    opcode_t op;
    logic [31:0] operand;
    logic [5:0] bit_count;
  } instr_t;

  typedef struct packed {
    logic less_than_flag;
    logic equal_flag;
    logic greater_than_flag;
    logic zero_result_flag;
    logic negative_result_flag;
  } flags_t;

  localparam flags_t FLAGS_RESET = 5'h00;

endpackage : acc_xor_cmp_pkg

// File: operand_memory.sv
// Model of the operand memory that feeds the unit its memory words.
`timescale 1ns/10ps
module operand_memory (
  // Word address.
  input wire logic [2:0] i_addr,
  // Addressed word low, the next word high.
  output logic [31:0] o_data
);
  localparam logic [15:0] MEM [8] = '{16'h0000, 16'h8000, 16'h1234, 16'hffff, 16'h0001, 16'h7fff, 16'h5a5a, 16'h0000};
  // The next word always rides in the upper half, so a word operation that leaks it is caught.
  assign o_data = {MEM[3'(i_addr + 3'h1)], MEM[i_addr]};
endmodule : operand_memory

// File: accumulator_xor_compare_unit_tb.sv
// Self-checking testbench for the accumulator xor and compare unit.
`timescale 1ns/10ps
module accumulator_xor_compare_unit_tb;
  localparam int SD = 4;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic i_valid = 1'b0;
  logic i_load = 1'b0;
  logic i_push = 1'b0;
  logic [31:0] i_load_value = 32'h0;
  logic [31:0] val = 32'h0;
  logic use_mem = 1'b0;
  logic [2:0] op = 3'h7;
  logic [5:0] cnt = 6'h0;
  logic [31:0] mem_data;
  acc_xor_cmp_pkg::instr_t i_instr;
  logic [31:0] o_acc;
  logic [31:0] o_stack_top;
  acc_xor_cmp_pkg::flags_t o_flags;
  logic o_done;
  logic [31:0] acc;
  logic [31:0] stk [SD];
  acc_xor_cmp_pkg::flags_t fl;
  int bad_count = 0;
  int comparisons = 0;
  always #50 i_clk_sys = ~i_clk_sys;
  assign i_instr = '{acc_xor_cmp_pkg::opcode_t'(op), use_mem ? mem_data : val, cnt};
  operand_memory u_mem (.i_addr(val[2:0]), .o_data(mem_data));
  accumulator_xor_compare_unit #(.STACK_DEPTH(SD)) u_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_valid(i_valid), .i_instr(i_instr), .i_load(i_load), .i_load_value(i_load_value), .i_push(i_push),
    .o_acc(o_acc), .o_stack_top(o_stack_top), .o_flags(o_flags), .o_done(o_done));
  task automatic tick();
    @(posedge i_clk_sys);
    #1;
  endtask : tick
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic chk_all(input logic done);
    check(o_acc, acc, "accumulator");
    check(o_stack_top, stk[0], "stack top");
    check(32'(o_flags), 32'(fl), "flags");
    check(32'(o_done), 32'(done), "done");
  endtask : chk_all
  task automatic clr();
    acc = 32'h0;
    fl = '0;
    for (int k = 0; k < SD; k++) stk[k] = 32'h0;
  endtask : clr
  function automatic logic [31:0] run_mask(input logic [5:0] c);
    int n;
    n = (c == 6'h0) ? 1 : (c > 6'h20) ? 32 : int'(c);
    return (n == 32) ? 32'hffff_ffff : (32'h1 << n) - 32'h1;
  endfunction : run_mask
  task automatic load(input logic [31:0] v, input logic p);
    i_load = 1'b1;
    i_push = p;
    i_load_value = v;
    tick();
    i_load = 1'b0;
    i_push = 1'b0;
    if (p) begin
      for (int k = SD - 1; k > 0; k--) stk[k] = stk[k - 1];
      stk[0] = acc;
    end
    acc = v;
    chk_all(1'b0);
  endtask : load
  // Codes 0 to 3 are the xor forms, 4 to 6 the compares, 7 the no-op. Set last to end a back-to-back run.
  task automatic exec(input logic [2:0] o, input logic [31:0] v, input logic m, input logic [5:0] c, input logic last);
    logic [31:0] a;
    logic [31:0] b;
    op = o;
    val = v;
    use_mem = m;
    cnt = c;
    i_valid = 1'b1;
    tick();
    b = i_instr.operand;
    if (o >= 3'h4 && o != 3'h7) begin
      a = (o == 3'h4) ? {16'h0, acc[15:0]} : acc;
      b = (o == 3'h4) ? {16'h0, b[15:0]} : (o == 3'h6) ? (b & run_mask(c)) : b;
      fl.less_than_flag = a < b;
      fl.equal_flag = a == b;
      fl.greater_than_flag = a > b;
    end else if (o != 3'h7) begin
      if (o == 3'h0) acc[15:0] = acc[15:0] ^ b[15:0];
      if (o == 3'h1) acc = acc ^ b;
      if (o == 3'h2) acc = acc ^ (b & run_mask(c));
      if (o == 3'h3) begin
        acc = acc ^ stk[0];
        for (int k = 0; k < SD - 1; k++) stk[k] = stk[k + 1];
        stk[SD - 1] = 32'h0;
      end
      fl.zero_result_flag = acc == 32'h0;
      fl.negative_result_flag = acc[31];
    end
    chk_all(1'b1);
    if (last) begin
      i_valid = 1'b0;
      op = 3'h7;
    end
  endtask : exec
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  // ********************
  // Scenarios
  // ********************
  initial begin
    clr();
    repeat (20) @(posedge i_clk_sys);
    #1;
    chk_all(1'b0);
    i_reset = 1'b0;
    // Five pushes into four levels, so the deepest value falls off.
    load(32'h8000_1234, 1'b0);
    for (int k = 1; k < 6; k++) load(32'h1111_1111 * k, 1'b1);
    $display("test load and push done");
    exec(3'h0, 32'h2, 1'b1, 6'h0, 1'b0);
    exec(3'h1, 32'h5555_5555, 1'b0, 6'h0, 1'b0);
    exec(3'h1, 32'hd555_5555, 1'b0, 6'h0, 1'b0);
    exec(3'h2, 32'hffff_ffff, 1'b0, 6'h1, 1'b0);
    exec(3'h2, 32'hffff_ffff, 1'b0, 6'h20, 1'b0);
    exec(3'h2, 32'hffff_ffff, 1'b0, 6'h0, 1'b0);
    exec(3'h2, 32'hffff_ffff, 1'b0, 6'h04, 1'b0);
    exec(3'h2, 32'hffff_ffff, 1'b0, 6'h28, 1'b1);
    $display("test xor forms done");
    load(32'hffff_0005, 1'b0);
    exec(3'h4, 32'h4, 1'b1, 6'h0, 1'b0);
    exec(3'h4, 32'h5, 1'b1, 6'h0, 1'b0);
    exec(3'h4, 32'h0000_0005, 1'b0, 6'h0, 1'b0);
    exec(3'h5, 32'h1, 1'b1, 6'h0, 1'b0);
    exec(3'h5, 32'hffff_0005, 1'b0, 6'h0, 1'b0);
    exec(3'h5, 32'hffff_ffff, 1'b0, 6'h0, 1'b0);
    exec(3'h6, 32'hffff_0005, 1'b0, 6'h20, 1'b0);
    exec(3'h6, 32'hffff_0005, 1'b0, 6'h10, 1'b1);
    // A load offered beside a compare must be ignored.
    i_load = 1'b1;
    i_load_value = 32'h0bad_0bad;
    exec(3'h6, 32'hffff_ffff, 1'b0, 6'h0, 1'b1);
    i_load = 1'b0;
    $display("test compares done");
    for (int k = 0; k < SD + 1; k++) exec(3'h3, 32'h0, 1'b0, 6'h0, k == SD);
    exec(3'h7, 32'hffff_ffff, 1'b0, 6'h0, 1'b1);
    $display("test stack xor done");
    i_reset = 1'b1;
    tick();
    clr();
    chk_all(1'b0);
    i_reset = 1'b0;
    exec(3'h1, 32'h8000_0001, 1'b0, 6'h0, 1'b1);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : accumulator_xor_compare_unit_tb
